// ### src/smau_core.sv
// shared memory atomic unit: decode of the memory instruction and single-cycle
// read-modify-write on a flip-flop word store and on the append counters
// assumes the sequencer issues at most one lane request per clock
// assumes index mode 3 never arrives and tessellation writes carry no counter select
// reset clears every word, every counter and the answer
`timescale 1ns/10ps
module smau_core
    import smau_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // request from the sequencer
    input wire logic req_valid,
    input wire logic req_first_active,
    input wire logic req_tessellation_factor,
    input wire logic [31:0] req_word1,
    input wire logic [31:0] req_word2,
    input wire smau_operands_t req_operands,
    input wire logic [ADDR_W-1:0] pair_index_offset,
    input wire logic [CNT_W-1:0] index_reg0,
    input wire logic [CNT_W-1:0] index_reg1,
    // answer to the sequencer
    output smau_resp_t resp
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [MEM_WORDS-1:0][31:0] mem;
        logic [NUM_COUNTERS-1:0][31:0] cnt;
        smau_resp_t resp;
    } smau_state_t;

    smau_state_t st_q;
    smau_state_t st_d;

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    logic [5:0] op;
    logic [6:0] dword_offset;
    logic [1:0] counter_index_mode;
    logic [3:0] counter_select;
    logic alloc_consume;
    logic broadcast_first_lane;
    logic returning;
    logic take;
    logic [CNT_W-1:0] cnt_idx;
    logic [ADDR_W-1:0] addr_a;
    logic [ADDR_W-1:0] addr_b;
    logic [ADDR_W-1:0] addr_second;

    assign op = req_word1[OP_HI:OP_LO];
    assign dword_offset = req_word1[DWOFS_HI:DWOFS_LO];
    assign counter_index_mode = req_word1[IDXM_HI:IDXM_LO];
    assign counter_select = req_word1[CSEL_HI:CSEL_LO];
    assign alloc_consume = req_word1[ALLOC_BIT];
    assign broadcast_first_lane = req_word1[BCAST_BIT];
    assign returning = (op >= FIRST_RETURNING);
    // other lanes of a broadcast request are dropped; the first one answers for all
    assign take = req_valid && !req_tessellation_factor
        && (!broadcast_first_lane || req_first_active);

    always_comb begin
        cnt_idx = counter_select;
        unique case (counter_index_mode)
            IDX_REG0: cnt_idx = CNT_W'(counter_select + index_reg0);
            IDX_REG1: cnt_idx = CNT_W'(counter_select + index_reg1);
            // mode 3 is never issued; it falls back to no indexing
            default: cnt_idx = counter_select;
        endcase
    end

    // dword offset applies to every shared-memory address
    assign addr_a = ADDR_W'(req_operands.addr0[ADDR_W-1:0] + ADDR_W'(dword_offset));
    assign addr_second = ADDR_W'(req_operands.addr1[ADDR_W-1:0] + ADDR_W'(dword_offset));

    always_comb begin
        unique case (op)
            // the strided partner sits whole rows of 64 words further on
            op_strided_pair_swap: addr_b = ADDR_W'(addr_a + (pair_index_offset << STRIDE_SHIFT));
            op_dual_read, op_read_then_store: addr_b = addr_second;
            default: addr_b = ADDR_W'(addr_a + pair_index_offset);
        endcase
    end

    // ----------------------------------------------------------------
    // operation
    // ----------------------------------------------------------------
    logic use_cnt;
    logic [31:0] old_a;
    logic [31:0] old_b;
    logic [31:0] src;
    logic we_a;
    logic we_b;
    logic [31:0] wd_a;
    logic [31:0] wd_b;
    logic [31:0] slot_a;
    logic [31:0] slot_b;

    // bit 30 redirects a returning atomic onto the selected counter
    assign use_cnt = alloc_consume && returning && (op != op_ordered_allocation);
    assign old_a = use_cnt ? st_q.cnt[cnt_idx] : st_q.mem[addr_a];
    assign old_b = st_q.mem[addr_b];
    assign src = req_operands.src0;

    always_comb begin
        we_a = 1'b0;
        we_b = 1'b0;
        wd_a = old_a;
        wd_b = old_b;
        slot_a = old_a;
        slot_b = 32'h0;
        unique case (op)
            // stores the low half of src0 and clears the upper half; no answer goes back
            op_halfword_store: begin
                we_a = 1'b1;
                wd_a = {16'h0, src[15:0]};
            end
            op_add_returning: begin
                we_a = 1'b1;
                wd_a = old_a + src;
            end
            op_sub_returning: begin
                we_a = 1'b1;
                wd_a = old_a - src;
            end
            op_rsub_returning: begin
                we_a = 1'b1;
                wd_a = src - old_a;
            end
            op_wrap_increment_returning: begin
                we_a = 1'b1;
                wd_a = (old_a >= src) ? 32'h0 : old_a + 32'h1;
            end
            op_wrap_decrement_returning: begin
                we_a = 1'b1;
                wd_a = (old_a == 32'h0 || old_a > src) ? src : old_a - 32'h1;
            end
            op_min_signed: begin
                we_a = 1'b1;
                wd_a = ($signed(old_a) < $signed(src)) ? old_a : src;
            end
            op_max_signed: begin
                we_a = 1'b1;
                wd_a = ($signed(old_a) > $signed(src)) ? old_a : src;
            end
            op_min_unsigned: begin
                we_a = 1'b1;
                wd_a = (old_a < src) ? old_a : src;
            end
            op_max_unsigned: begin
                we_a = 1'b1;
                wd_a = (old_a > src) ? old_a : src;
            end
            op_and_returning: begin
                we_a = 1'b1;
                wd_a = old_a & src;
            end
            op_or_returning: begin
                we_a = 1'b1;
                wd_a = old_a | src;
            end
            op_xor_returning: begin
                we_a = 1'b1;
                wd_a = old_a ^ src;
            end
            // src0 is the mask, src1 the bits to set
            op_masked_or_returning: begin
                we_a = 1'b1;
                wd_a = (old_a & ~src) | req_operands.src1;
            end
            op_swap_returning: begin
                we_a = 1'b1;
                wd_a = src;
            end
            op_pair_swap, op_strided_pair_swap: begin
                we_a = 1'b1;
                we_b = 1'b1;
                wd_a = src;
                wd_b = req_operands.src1;
                slot_b = old_b;
            end
            // src0 is the compare value, src1 the new word
            op_compare_swap, op_compare_swap_alt: begin
                we_a = (old_a == src);
                wd_a = req_operands.src1;
            end
            op_read: slot_a = old_a;
            op_pair_read, op_dual_read: slot_b = old_b;
            op_read_then_store: begin
                we_b = 1'b1;
                wd_b = src;
            end
            op_byte_read_signed: slot_a = {{24{old_a[7]}}, old_a[7:0]};
            op_byte_read_unsigned: slot_a = {24'h0, old_a[7:0]};
            op_half_read_signed: slot_a = {{16{old_a[15]}}, old_a[15:0]};
            op_half_read_unsigned: slot_a = {16'h0, old_a[15:0]};
            // the counter add itself happens at the write ports
            op_ordered_allocation: begin
                slot_a = st_q.cnt[cnt_idx];
            end
            default: slot_a = 32'h0;
        endcase
    end

    // ----------------------------------------------------------------
    // destination component selects
    // ----------------------------------------------------------------
    logic [3:0][31:0] srcv;
    logic [3:0][31:0] comp_val;
    logic [3:0] comp_off;

    assign srcv = {32'h0, 32'h0, slot_b, slot_a};

    for (genvar c = 0; c < 4; c++) begin : g_comp
        logic [SEL_W-1:0] sel;
        assign sel = req_word2[c*SEL_W +: SEL_W];
        // codes 6 and 7 both drop the component, so no reserved code leaks a value
        assign comp_off[c] = (sel > SEL_ONE);
        assign comp_val[c] = (sel == SEL_ONE) ? FLOAT_ONE
            : ((sel < SEL_ZERO) ? srcv[sel[1:0]] : 32'h0);
    end

    // ----------------------------------------------------------------
    // write ports
    // ----------------------------------------------------------------
    logic cnt_we;
    logic [31:0] cnt_wd;
    logic mem_we_a;
    logic mem_we_b;

    // a refused request, a dropped lane or a tessellation factor write touches nothing
    assign cnt_we = take && ((op == op_ordered_allocation) || (use_cnt && we_a));
    assign cnt_wd = (op == op_ordered_allocation)
        ? st_q.cnt[cnt_idx] + {25'h0, req_operands.addr0[ALLOC_ADD_W-1:0]}
        : wd_a;
    assign mem_we_a = take && we_a && !use_cnt && (op != op_ordered_allocation);
    assign mem_we_b = take && we_b;

    // ----------------------------------------------------------------
    // next state: memory, counters and answer all settle in one edge
    // ----------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        st_d.resp.valid = take && returning;
        st_d.resp.broadcast_all = take && returning && broadcast_first_lane;
        // reads and writes of one request land on the same edge, so no other
        // request can slip between them
        if (cnt_we) begin
            st_d.cnt[cnt_idx] = cnt_wd;
        end
        if (mem_we_a) begin
            st_d.mem[addr_a] = wd_a;
        end
        // when both addresses of a pair coincide the second write wins
        if (mem_we_b) begin
            st_d.mem[addr_b] = wd_b;
        end
        if (take && returning) begin
            st_d.resp.return_slot_a = slot_a;
            st_d.resp.return_slot_b = slot_b;
            st_d.resp.comp_mask = comp_off;
            st_d.resp.comp = comp_val;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign resp = st_q.resp;

endmodule : smau_core

// ### src/smau_pkg.sv
// shared memory atomic unit: constants, field positions, opcodes and carriers
// assumes one clock domain and a sequencer that presents one lane request per cycle
package smau_pkg;

    // ----------------------------------------------------------------
    // storage sizes
    // ----------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int MEM_WORDS = 256;
    localparam int CNT_W = 4;
    localparam int NUM_COUNTERS = 16;
    localparam int STRIDE_SHIFT = 6;

    // ----------------------------------------------------------------
    // second dword field positions
    // ----------------------------------------------------------------
    localparam int OP_LO = 9;
    localparam int OP_HI = 14;
    localparam int DWOFS_LO = 16;
    localparam int DWOFS_HI = 22;
    localparam int IDXM_LO = 24;
    localparam int IDXM_HI = 25;
    localparam int CSEL_LO = 26;
    localparam int CSEL_HI = 29;
    localparam int ALLOC_BIT = 30;
    localparam int BCAST_BIT = 31;
    localparam int ALLOC_ADD_W = 7;

    // ----------------------------------------------------------------
    // destination selects in the third dword
    // ----------------------------------------------------------------
    localparam int SEL_W = 3;
    localparam logic [2:0] SEL_ZERO = 3'h4;
    localparam logic [2:0] SEL_ONE = 3'h5;
    localparam logic [31:0] FLOAT_ONE = 32'h3f800000;

    // ----------------------------------------------------------------
    // counter index modes
    // ----------------------------------------------------------------
    localparam logic [1:0] IDX_NONE = 2'h0;
    localparam logic [1:0] IDX_REG0 = 2'h1;
    localparam logic [1:0] IDX_REG1 = 2'h2;

    // ----------------------------------------------------------------
    // operation codes
    // ----------------------------------------------------------------
    typedef enum logic [5:0] {
        op_halfword_store = 6'h13,
        op_add_returning = 6'h20, op_sub_returning = 6'h21, op_rsub_returning = 6'h22,
        op_wrap_increment_returning = 6'h23, op_wrap_decrement_returning = 6'h24,
        op_min_signed = 6'h25, op_max_signed = 6'h26,
        op_min_unsigned = 6'h27, op_max_unsigned = 6'h28,
        op_and_returning = 6'h29, op_or_returning = 6'h2a, op_xor_returning = 6'h2b,
        op_masked_or_returning = 6'h2c, op_swap_returning = 6'h2d,
        op_pair_swap = 6'h2e, op_strided_pair_swap = 6'h2f,
        op_compare_swap = 6'h30, op_compare_swap_alt = 6'h31,
        op_read = 6'h32, op_pair_read = 6'h33, op_dual_read = 6'h34,
        op_read_then_store = 6'h35,
        op_byte_read_signed = 6'h36, op_byte_read_unsigned = 6'h37,
        op_half_read_signed = 6'h38, op_half_read_unsigned = 6'h39,
        op_ordered_allocation = 6'h3f
    } smau_op_t;

    localparam logic [5:0] FIRST_RETURNING = 6'h20;

    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [31:0] addr0;
        logic [31:0] addr1;
        logic [31:0] src0;
        logic [31:0] src1;
    } smau_operands_t;

    typedef struct packed {
        logic valid;
        logic broadcast_all;
        logic [3:0] comp_mask;
        logic [3:0][31:0] comp;
        logic [31:0] return_slot_a;
        logic [31:0] return_slot_b;
    } smau_resp_t;

endpackage : smau_pkg

// ### tb/smau_core_assertions.sv
// checker for smau_core: answer timing, refusals, extensions and selects
// bound to every smau_core instance; one clock, reset active high
`timescale 1ns/10ps
module smau_core_checker
    import smau_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // request and answer
    input wire logic req_valid,
    input wire logic req_first_active,
    input wire logic req_tessellation_factor,
    input wire logic [31:0] req_word1,
    input wire logic [31:0] req_word2,
    input wire smau_resp_t resp
);
    logic [5:0] op_w;
    logic take_w;
    assign op_w = req_word1[OP_HI:OP_LO];
    assign take_w = req_valid && !req_tessellation_factor
        && (!req_word1[BCAST_BIT] || req_first_active);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    answer_follows_a: assert property (take_w && op_w >= FIRST_RETURNING |=> resp.valid)
        else $error("answer missing");
    answer_cause_a: assert property (resp.valid |-> $past(take_w)
        && $past(op_w) >= FIRST_RETURNING) else $error("answer without request");
    half_store_quiet_a: assert property (take_w && op_w == 6'h13 |=> !resp.valid)
        else $error("answer to half store");
    tf_refused_a: assert property (req_valid && req_tessellation_factor |=> !resp.valid)
        else $error("answer to tf write");
    bcast_flag_a: assert property (resp.valid |-> resp.broadcast_all
        == $past(req_word1[BCAST_BIT])) else $error("broadcast flag wrong");
    byte_sext_a: assert property (resp.valid && $past(op_w) == 6'h36
        |-> resp.return_slot_a[31:8] == {24{resp.return_slot_a[7]}}) else $error("byte ext");
    byte_zext_a: assert property (resp.valid && $past(op_w) == 6'h37
        |-> resp.return_slot_a[31:8] == 24'h0) else $error("ubyte ext");
    half_sext_a: assert property (resp.valid && $past(op_w) == 6'h38
        |-> resp.return_slot_a[31:16] == {16{resp.return_slot_a[15]}}) else $error("half ext");
    half_zext_a: assert property (resp.valid && $past(op_w) == 6'h39
        |-> resp.return_slot_a[31:16] == 16'h0) else $error("uhalf ext");
    sel_one_a: assert property (resp.valid && $past(req_word2[11:9]) == SEL_ONE
        |-> resp.comp[3] == FLOAT_ONE) else $error("one select");
    sel_mask_a: assert property (resp.valid && $past(req_word2[11:9]) == 3'h7
        |-> resp.comp_mask[3]) else $error("mask select");
    cover property (resp.valid && resp.broadcast_all);
    cover property (resp.valid ##1 resp.valid);
    cover property (resp.valid && resp.comp_mask == 4'hf);
endmodule : smau_core_checker

bind smau_core smau_core_checker u_smau_core_checker (
    .clk_sys(clk_sys),
    .rst(rst),
    .req_valid(req_valid),
    .req_first_active(req_first_active),
    .req_tessellation_factor(req_tessellation_factor),
    .req_word1(req_word1),
    .req_word2(req_word2),
    .resp(resp)
);

// ### tb/smau_core_bench.sv
// bench for smau_core: directed scenarios through the sequencer model
// assumes a 125 MHz clock and the constants of smau_pkg
`timescale 1ns/10ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin errors++; \
    $display("mismatch %0t %h %h", $time, (a), (e)); end end
module smau_core_bench
    import smau_pkg::*;
;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic req_valid, req_first_active, req_tessellation_factor;
    logic [31:0] req_word1, req_word2;
    smau_operands_t req_operands;
    logic [ADDR_W-1:0] pair_index_offset;
    logic [CNT_W-1:0] index_reg0, index_reg1;
    smau_resp_t resp;
    int errors = 0;
    int comparisons = 0;
    localparam logic [31:0] OV [3] = '{32'h80000005, 32'h0, 32'hffffff85};
    localparam logic [31:0] SV [3] = '{32'h7, 32'h3, 32'hffffff85};
    localparam logic [31:0] TV [3] = '{32'hf0f0, 32'h12345678, 32'h5a5a0001};
    smau_seq_model u_smau_seq_model (
        .clk_sys(clk_sys),
        .req_valid(req_valid),
        .req_first_active(req_first_active),
        .req_tessellation_factor(req_tessellation_factor),
        .req_word1(req_word1),
        .req_word2(req_word2),
        .req_operands(req_operands),
        .pair_index_offset(pair_index_offset),
        .index_reg0(index_reg0),
        .index_reg1(index_reg1)
    );
    smau_core u_smau_core (
        .clk_sys(clk_sys),
        .rst(rst),
        .req_valid(req_valid),
        .req_first_active(req_first_active),
        .req_tessellation_factor(req_tessellation_factor),
        .req_word1(req_word1),
        .req_word2(req_word2),
        .req_operands(req_operands),
        .pair_index_offset(pair_index_offset),
        .index_reg0(index_reg0),
        .index_reg1(index_reg1),
        .resp(resp)
    );
    initial forever #4 clk_sys = ~clk_sys;
    function automatic logic [31:0] w1f(input logic [5:0] op, input logic [6:0] ofs,
        input logic [7:0] hi);
        return {hi, 1'b0, ofs, 1'b0, op, 9'h0};
    endfunction : w1f
    function automatic logic [31:0] nv(input int op, input logic [31:0] o, s, t);
        case (op)
            32: return o + s;
            33: return o - s;
            34: return s - o;
            35: return (o >= s) ? 32'h0 : o + 1;
            36: return (o == 0 || o > s) ? s : o - 1;
            37: return ($signed(o) < $signed(s)) ? o : s;
            38: return ($signed(o) > $signed(s)) ? o : s;
            39: return (o < s) ? o : s;
            40: return (o > s) ? o : s;
            41: return o & s;
            42: return o | s;
            43: return o ^ s;
            44: return (o & ~s) | t;
            45, 46, 47: return s;
            48, 49: return (o == s) ? t : o;
            default: return o;
        endcase
    endfunction : nv
    function automatic logic [31:0] rv(input int op, input logic [31:0] o);
        case (op)
            54: return {{24{o[7]}}, o[7:0]};
            55: return {24'h0, o[7:0]};
            56: return {{16{o[15]}}, o[15:0]};
            57: return {16'h0, o[15:0]};
            default: return o;
        endcase
    endfunction : rv
    task automatic go(input logic [31:0] w1, a0, a1, s0, s1);
        u_smau_seq_model.req(w1, 12'hb08, a0, a1, s0, s1, 1'b1, 1'b0);
        u_smau_seq_model.idle();
        #1;
    endtask : go
    task automatic atomics_test;
        for (int i = 0; i < 3; i++) begin
            for (int op = 32; op < 58; op++) begin
                go(w1f(6'h2d, 7'h0, 8'h0), 32'h8, 32'h40, OV[i], 32'h0);
                go(w1f(6'(op), 7'h0, 8'h0), 32'h8, 32'h40, SV[i], TV[i]);
                `CHK(resp.return_slot_a, rv(op, OV[i]))
                go(w1f(6'h32, 7'h0, 8'h0), 32'h8, 32'h0, 32'h0, 32'h0);
                `CHK(resp.return_slot_a, nv(op, OV[i], SV[i], TV[i]))
            end
        end
    endtask : atomics_test
    task automatic pair_test;
        go(w1f(6'h2d, 7'h0, 8'h0), 32'h20, 32'h0, 32'h11, 32'h0);
        go(w1f(6'h2d, 7'h0, 8'h0), 32'h21, 32'h0, 32'h22, 32'h0);
        go(w1f(6'h2d, 7'h0, 8'h0), 32'h60, 32'h0, 32'h33, 32'h0);
        go(w1f(6'h2e, 7'h0, 8'h0), 32'h20, 32'h0, 32'haa, 32'hbb);
        `CHK(resp.return_slot_b, 32'h22)
        go(w1f(6'h2f, 7'h0, 8'h0), 32'h20, 32'h0, 32'hcc, 32'hdd);
        `CHK(resp.return_slot_b, 32'h33)
        go(w1f(6'h33, 7'h0, 8'h0), 32'h20, 32'h0, 32'h0, 32'h0);
        `CHK({resp.return_slot_a, resp.return_slot_b}, {32'hcc, 32'hbb})
        `CHK({resp.comp[0], resp.comp[1]}, {32'hcc, 32'hbb})
        go(w1f(6'h34, 7'h0, 8'h0), 32'h60, 32'h21, 32'h0, 32'h0);
        `CHK({resp.return_slot_a, resp.return_slot_b}, {32'hdd, 32'hbb})
        go(w1f(6'h35, 7'h0, 8'h0), 32'h20, 32'h60, 32'hee, 32'h0);
        `CHK(resp.return_slot_a, 32'hcc)
        go(w1f(6'h32, 7'h0, 8'h0), 32'h60, 32'h0, 32'h0, 32'h0);
        `CHK(resp.return_slot_a, 32'hee)
    endtask : pair_test
    task automatic misc_test;
        go(w1f(6'h2d, 7'h05, 8'h0), 32'h10, 32'h0, 32'h77, 32'h0);
        go(w1f(6'h32, 7'h0, 8'h0), 32'h15, 32'h0, 32'h0, 32'h0);
        `CHK(resp.return_slot_a, 32'h77)
        `CHK({resp.comp[0], resp.comp[2], resp.comp[3]}, {32'h77, 32'h0, FLOAT_ONE})
        u_smau_seq_model.req(w1f(6'h32, 7'h0, 8'h0), 12'hfff, 32'h15, 0, 0, 0, 1'b1, 1'b0);
        u_smau_seq_model.idle();
        #1 `CHK({resp.comp_mask, resp.comp[0]}, {4'hf, 32'h0})
        u_smau_seq_model.req(w1f(6'h13, 7'h0, 8'h0), 12'hb08, 32'h15, 0, 32'habcd1234, 0,
            1'b1, 1'b0);
        u_smau_seq_model.idle();
        #1 `CHK(resp.valid, 1'b0)
        u_smau_seq_model.req(w1f(6'h2d, 7'h0, 8'h0), 12'hb08, 32'h15, 0, 32'h5555, 0,
            1'b1, 1'b1);
        u_smau_seq_model.idle();
        #1 `CHK(resp.valid, 1'b0)
        u_smau_seq_model.req(w1f(6'h32, 7'h0, 8'h80), 12'hb08, 32'h15, 0, 0, 0, 1'b0, 1'b0);
        u_smau_seq_model.idle();
        #1 `CHK(resp.valid, 1'b0)
        go(w1f(6'h32, 7'h0, 8'h80), 32'h15, 32'h0, 32'h0, 32'h0);
        `CHK({resp.broadcast_all, resp.return_slot_a}, {1'b1, 32'h1234})
        go(w1f(6'h2d, 7'h0, 8'h0), 32'h30, 32'h0, 32'h1, 32'h0);
        u_smau_seq_model.req(w1f(6'h20, 7'h0, 8'h0), 12'hb08, 32'h30, 0, 32'h2, 0, 1'b1, 1'b0);
        u_smau_seq_model.req(w1f(6'h20, 7'h0, 8'h0), 12'hb08, 32'h30, 0, 32'h3, 0, 1'b1, 1'b0);
        #1 `CHK(resp.return_slot_a, 32'h1)
        u_smau_seq_model.idle();
        #1 `CHK(resp.return_slot_a, 32'h3)
    endtask : misc_test
    task automatic counter_test;
        go(w1f(6'h3f, 7'h0, 8'h88), 32'h85, 32'h0, 32'h0, 32'h0);
        `CHK(resp.return_slot_a, 32'h0)
        go(w1f(6'h3f, 7'h0, 8'h88), 32'h85, 32'h0, 32'h0, 32'h0);
        `CHK(resp.return_slot_a, 32'h5)
        go(w1f(6'h3f, 7'h0, 8'h85), 32'h85, 32'h0, 32'h0, 32'h0);
        `CHK(resp.return_slot_a, 32'ha)
        go(w1f(6'h3f, 7'h0, 8'hbe), 32'h85, 32'h0, 32'h0, 32'h0);
        `CHK(resp.return_slot_a, 32'hf)
        go(w1f(6'h20, 7'h0, 8'h48), 32'h0, 32'h0, 32'h1, 32'h0);
        `CHK(resp.return_slot_a, 32'h14)
    endtask : counter_test
    task automatic reset_test;
        @(posedge clk_sys);
        rst <= 1'b1;
        @(posedge clk_sys);
        rst <= 1'b0;
        go(w1f(6'h32, 7'h0, 8'h0), 32'h15, 32'h0, 32'h0, 32'h0);
        `CHK({resp.valid, resp.return_slot_a}, {1'b1, 32'h0})
        go(w1f(6'h3f, 7'h0, 8'h88), 32'h85, 32'h0, 32'h0, 32'h0);
        `CHK(resp.return_slot_a, 32'h0)
    endtask : reset_test
    task automatic finish_test;
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : finish_test
    initial begin
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        atomics_test();
        pair_test();
        misc_test();
        counter_test();
        reset_test();
        finish_test();
    end
    initial begin
        #(8 * 5000);
        errors++;
        finish_test();
    end
endmodule : smau_core_bench

// ### tb/smau_seq_model.sv
// sequencer model: presents one lane request per call to the unit
// assumes the caller calls idle to end a run of requests
`timescale 1ns/10ps
module smau_seq_model
    import smau_pkg::*;
(
    // clock
    input wire logic clk_sys,
    // request to the unit
    output logic req_valid,
    output logic req_first_active,
    output logic req_tessellation_factor,
    output logic [31:0] req_word1,
    output logic [31:0] req_word2,
    output smau_operands_t req_operands,
    output logic [ADDR_W-1:0] pair_index_offset,
    output logic [CNT_W-1:0] index_reg0,
    output logic [CNT_W-1:0] index_reg1
);
    initial begin
        req_valid = 1'b0;
        req_first_active = 1'b0;
        req_tessellation_factor = 1'b0;
        req_word1 = 32'h0;
        req_word2 = 32'h0;
        req_operands = '0;
        pair_index_offset = 8'h01;
        index_reg0 = 4'h1;
        index_reg1 = 4'h3;
    end
    task automatic req(input logic [31:0] w1, input logic [11:0] w2,
        input logic [31:0] a0, a1, s0, s1, input logic f, t);
        logic [31:0] w;
        w = w1;
        if (w[OP_HI:OP_LO] == 6'h3f) w[BCAST_BIT] = 1'b1;
        if (w[IDXM_HI:IDXM_LO] == 2'h3) w[IDXM_HI:IDXM_LO] = IDX_NONE;
        if (t) w[CSEL_HI:CSEL_LO] = 4'h0;
        @(posedge clk_sys);
        req_valid <= 1'b1;
        req_first_active <= f;
        req_tessellation_factor <= t;
        req_word1 <= w;
        req_word2 <= {20'h0, w2};
        req_operands <= {a0, a1, s0, s1};
    endtask : req
    task automatic idle;
        @(posedge clk_sys);
        req_valid <= 1'b0;
        req_operands <= ~req_operands;
    endtask : idle
endmodule : smau_seq_model
